// ===== src/lcdpds_regs.svh
`ifndef LCDPDS_REGS_SVH
`define LCDPDS_REGS_SVH

// ****************************************
// Register byte addresses
// ****************************************
`define LCDPDS_PORT_CTRL_ADDR   16'hffc0
`define LCDPDS_DISP_CTRL_ADDR   16'hffc1
`define LCDPDS_STATUS_ADDR      16'hffc4
`define LCDPDS_RAM_BASE         16'hf740
`define LCDPDS_RAM_BYTES        64

// ****************************************
// Reset values and fields
// ****************************************
`define LCDPDS_PORT_CTRL_RST    8'h00
`define LCDPDS_DISP_CTRL_RST    8'h80
`define LCDPDS_DUTY_MSB         7
`define LCDPDS_DUTY_LSB         6
`define LCDPDS_CMX_BIT          5
`define LCDPDS_SGX_BIT          4
`define LCDPDS_SGS_MSB          3
`define LCDPDS_DISP_ACT_BIT     5
`define LCDPDS_DISP_CKS_MSB     3

// ****************************************
// Capacities and frame rates
// ****************************************
`define LCDPDS_SEG_PINS         40
`define LCDPDS_SEG_INT_EXP      36
`define LCDPDS_FRAME_CHOICES    11
`define LCDPDS_EXT_SEG_STATIC   476
`define LCDPDS_EXT_SEG_HALF     220
`define LCDPDS_EXT_SEG_THIRD    92
`define LCDPDS_EXT_SEG_QUARTER  92

`endif

// ===== src/lcdpds_pkg.sv
package lcdpds_pkg;
    typedef enum logic [1:0] {
        LCDPDS_STATIC  = 2'h0,
        LCDPDS_HALF    = 2'h1,
        LCDPDS_THIRD   = 2'h2,
        LCDPDS_QUARTER = 2'h3
    } lcdpds_duty_t;

    typedef enum logic [1:0] {
        LCDPDS_IDLE  = 2'h0,
        LCDPDS_WRESP = 2'h1,
        LCDPDS_RRESP = 2'h2
    } lcdpds_bus_t;
endpackage

// ===== src/lcdpds_pin_decode.sv
`timescale 1ns/10ps
`include "lcdpds_regs.svh"

// Pure decode of port control into pin functions
module lcdpds_pin_decode
    import lcdpds_pkg::*;
(
    // Control fields
    input  wire lcdpds_duty_t duty,
    input  wire logic         common_multiplex,
    input  wire logic         expansion_select,
    input  wire logic [3:0]   segment_group_sel,
    // Pin functions
    output logic [3:0]        com_drive,
    output logic [3:0]        com_src1,
    output logic              com4_nonsel,
    output logic [9:0]        seg_group_drive,
    output logic              exp_active
);
    function automatic logic [9:0] group_map(input logic [3:0] s, input logic x);
        logic [9:0] g;
        g = 10'h000;
        // Groups numbered 0 = pins 1..4 up to 9 = pins 37..40
        if (s[3])
            g = s[0] ? 10'h3ff : 10'h3fe;
        else if (s[2:0] != 3'h0)
            g = (10'h3ff << (4'd9 - {1'b0, s[2:0]})) & 10'h3ff;
        if (s[3] && s[0] == 1'b0)
            g = 10'h3fe;
        if (!s[3] && s[2:0] != 3'h0) begin
            g = 10'h000;
            for (int i = 0; i < 10; i++)
                if (i >= 9 - s[2:0] && i <= 8)
                    g[i] = 1'b1;
            if (s[2:0] >= 3'h4)
                g[9] = 1'b1;
            if (s[2:0] < 3'h4)
                g[9] = 1'b1;
        end
        if (x)
            g[9] = 1'b0;
        return g;
    endfunction

    always_comb begin
        logic all_port;
        all_port = !expansion_select && segment_group_sel == 4'h0;
        seg_group_drive = group_map(segment_group_sel, expansion_select);
        exp_active = expansion_select && segment_group_sel != 4'h0;
        com_src1 = 4'h0;
        com4_nonsel = 1'b0;
        unique case (duty)
            LCDPDS_STATIC:  com_drive = common_multiplex ? 4'hf : 4'h1;
            LCDPDS_HALF:    com_drive = common_multiplex ? 4'hf : 4'h3;
            LCDPDS_THIRD:   com_drive = common_multiplex ? 4'hf : 4'h7;
            LCDPDS_QUARTER: com_drive = 4'hf;
        endcase
        if (common_multiplex && duty == LCDPDS_STATIC)
            com_src1 = 4'he;
        if (common_multiplex && duty == LCDPDS_HALF)
            com_src1 = 4'h2;
        if (common_multiplex && duty == LCDPDS_THIRD)
            com4_nonsel = 1'b1;
        if (all_port) begin
            com_drive = 4'h0;
            com4_nonsel = 1'b0;
        end
    end
endmodule

// ===== src/lcdpds_top.sv
// Design decision made here: the AXI4-Lite slave port.
`timescale 1ns/10ps
`include "lcdpds_regs.svh"

module lcdpds_top
    import lcdpds_pkg::*;
(
    // Clock and reset
    input  wire logic        mclk,
    input  wire logic        resetn,
    // AXI4-Lite write
    input  wire logic [15:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // AXI4-Lite read
    input  wire logic [15:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // Chip mode and waveform sources
    input  wire logic        standby,
    input  wire logic [3:0]  com_wave,
    input  wire logic        com_nonsel_wave,
    input  wire logic [39:0] seg_wave,
    input  wire logic        exp_latch_in,
    input  wire logic        exp_shift_in,
    input  wire logic        exp_data_in,
    input  wire logic        exp_alt_in,
    // Pins
    output logic [3:0]       com_out,
    output logic [3:0]       com_oe,
    output logic [39:0]      segment_output,
    output logic [39:0]      seg_oe,
    output logic [7:0]       lcd_port_duty_control,
    output logic [3:0]       frame_select
);
    typedef struct packed {
        logic [7:0]   port_ctrl;
        logic [7:0]   disp_ctrl;
        logic [1:0]   stby_sync;
        logic [15:0]  awaddr;
        logic         aw_held;
        logic [31:0]  wdata;
        logic [3:0]   wstrb;
        logic         w_held;
        lcdpds_bus_t  bus;
        logic         arready;
        logic [31:0]  rdata;
        logic [1:0]   resp;
        logic [3:0]   com_out;
        logic [3:0]   com_oe;
        logic [39:0]  seg_out;
        logic [39:0]  seg_oe;
    } lcdpds_state_t;

    lcdpds_state_t s_q;
    lcdpds_state_t s_d;
    logic [7:0]    ram_q [`LCDPDS_RAM_BYTES];

    logic [3:0]    com_drive;
    logic [3:0]    com_src1;
    logic          com4_nonsel;
    logic [9:0]    seg_group_drive;
    logic          exp_active;

    // ****************************************
    // Pin function decode
    // ****************************************
    lcdpds_pin_decode u_decode (
        .duty              (lcdpds_duty_t'(s_q.port_ctrl[`LCDPDS_DUTY_MSB:`LCDPDS_DUTY_LSB])),
        .common_multiplex  (s_q.port_ctrl[`LCDPDS_CMX_BIT]),
        .expansion_select  (s_q.port_ctrl[`LCDPDS_SGX_BIT]),
        .segment_group_sel (s_q.port_ctrl[`LCDPDS_SGS_MSB:0]),
        .com_drive         (com_drive),
        .com_src1          (com_src1),
        .com4_nonsel       (com4_nonsel),
        .seg_group_drive   (seg_group_drive),
        .exp_active        (exp_active)
    );

    function automatic logic ram_hit(input logic [15:0] a);
        return a >= `LCDPDS_RAM_BASE && a < `LCDPDS_RAM_BASE + 16'(`LCDPDS_RAM_BYTES);
    endfunction

    function automatic logic reg_hit(input logic [15:0] a);
        return {a[15:2], 2'h0} == `LCDPDS_PORT_CTRL_ADDR || ram_hit(a);
    endfunction

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        logic        do_write;
        logic        run;
        run = s_q.disp_ctrl[`LCDPDS_DISP_ACT_BIT] && !s_q.stby_sync[1];
        s_d = s_q;
        do_write = 1'b0;
        s_d.stby_sync = {s_q.stby_sync[0], standby};
        if (s_axi_awvalid && !s_q.aw_held && s_q.bus == LCDPDS_IDLE) begin
            s_d.awaddr = s_axi_awaddr;
            s_d.aw_held = 1'b1;
        end
        if (s_axi_wvalid && !s_q.w_held && s_q.bus == LCDPDS_IDLE) begin
            s_d.wdata = s_axi_wdata;
            s_d.wstrb = s_axi_wstrb;
            s_d.w_held = 1'b1;
        end
        s_d.arready = 1'b0;
        unique case (s_q.bus)
            LCDPDS_IDLE: begin
                if (s_q.aw_held && s_q.w_held) begin
                    do_write = 1'b1;
                    s_d.aw_held = 1'b0;
                    s_d.w_held = 1'b0;
                    s_d.resp = reg_hit(s_q.awaddr) ? 2'h0 : 2'h2;
                    s_d.bus = LCDPDS_WRESP;
                end else if (s_axi_arvalid && !s_q.arready) begin
                    s_d.arready = 1'b1;
                    s_d.rdata = 32'h0;
                    s_d.resp = 2'h0;
                    if ({s_axi_araddr[15:2], 2'h0} == `LCDPDS_PORT_CTRL_ADDR)
                        s_d.rdata = {16'h0, s_q.disp_ctrl, s_q.port_ctrl};
                    else if ({s_axi_araddr[15:2], 2'h0} == `LCDPDS_STATUS_ADDR)
                        s_d.rdata = {22'h0, exp_active, s_q.stby_sync[1], com_drive, 4'h0};
                    else if (ram_hit(s_axi_araddr))
                        s_d.rdata = {ram_q[{s_axi_araddr[5:2], 2'h3}],
                                     ram_q[{s_axi_araddr[5:2], 2'h2}],
                                     ram_q[{s_axi_araddr[5:2], 2'h1}],
                                     ram_q[{s_axi_araddr[5:2], 2'h0}]};
                    else
                        s_d.resp = 2'h2;
                    s_d.bus = LCDPDS_RRESP;
                end
            end
            LCDPDS_WRESP: if (s_axi_bready) s_d.bus = LCDPDS_IDLE;
            LCDPDS_RRESP: if (s_axi_rready) s_d.bus = LCDPDS_IDLE;
            default: s_d.bus = LCDPDS_IDLE;
        endcase
        // Port control in byte 0, display control in byte 1
        if (do_write && {s_q.awaddr[15:2], 2'h0} == `LCDPDS_PORT_CTRL_ADDR) begin
            if (s_q.wstrb[0])
                s_d.port_ctrl = s_q.wdata[7:0];
            if (s_q.wstrb[1])
                s_d.disp_ctrl = {1'b1, s_q.wdata[14:8]};
        end
        // Display drive
        for (int c = 0; c < 4; c++) begin
            s_d.com_oe[c] = com_drive[c];
            if (!run)
                s_d.com_out[c] = 1'b0;
            else if (c == 3 && com4_nonsel)
                s_d.com_out[c] = com_nonsel_wave;
            else if (com_src1[c])
                s_d.com_out[c] = (c == 3) ? com_wave[2] : com_wave[0];
            else
                s_d.com_out[c] = com_wave[c];
        end
        if (com_src1 == 4'he)
            s_d.com_out[3:1] = {3{run && com_wave[0]}};
        // Half duty paralleled: upper pair carries the second common waveform
        if (com_src1 == 4'h2)
            s_d.com_out[3:2] = {2{run && com_wave[1]}};
        for (int p = 0; p < `LCDPDS_SEG_PINS; p++) begin
            s_d.seg_oe[p] = seg_group_drive[p / 4];
            s_d.seg_out[p] = run && seg_group_drive[p / 4] && seg_wave[p];
        end
        if (exp_active) begin
            s_d.seg_oe[39:36] = 4'hf;
            s_d.seg_out[39:36] = run ? {exp_latch_in, exp_shift_in, exp_data_in, exp_alt_in}
                                     : 4'h0;
        end
    end

    // ****************************************
    // Registers
    // ****************************************
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            s_q <= '0;
            s_q.port_ctrl <= `LCDPDS_PORT_CTRL_RST;
            s_q.disp_ctrl <= `LCDPDS_DISP_CTRL_RST;
        end else begin
            s_q <= s_d;
        end
    end

    // Display memory, byte lanes, no reset by design
    always_ff @(posedge mclk) begin
        if (resetn && s_q.bus == LCDPDS_IDLE && s_q.aw_held && s_q.w_held
            && ram_hit(s_q.awaddr)) begin
            for (int b = 0; b < 4; b++)
                if (s_q.wstrb[b])
                    ram_q[{s_q.awaddr[5:2], 2'(b)}] <= s_q.wdata[8*b +: 8];
        end
    end

    assign s_axi_awready = !s_q.aw_held && s_q.bus == LCDPDS_IDLE;
    assign s_axi_wready  = !s_q.w_held && s_q.bus == LCDPDS_IDLE;
    assign s_axi_bvalid  = s_q.bus == LCDPDS_WRESP;
    assign s_axi_bresp   = s_q.resp;
    assign s_axi_arready = s_q.arready;
    assign s_axi_rvalid  = s_q.bus == LCDPDS_RRESP;
    assign s_axi_rresp   = s_q.resp;
    assign s_axi_rdata   = s_q.rdata;
    assign com_out        = s_q.com_out;
    assign com_oe         = s_q.com_oe;
    assign segment_output = s_q.seg_out;
    assign seg_oe         = s_q.seg_oe;
    assign lcd_port_duty_control = s_q.port_ctrl;
    assign frame_select   = s_q.disp_ctrl[`LCDPDS_DISP_CKS_MSB:0];

    // ****************************************
    // Checks
    // ****************************************
    a_reset_value: assert property (@(posedge mclk) !resetn |=> s_q.port_ctrl == 8'h00)
        else $error("port control not zero after reset");
    a_all_port: assert property (@(posedge mclk) disable iff (!resetn)
        (s_q.port_ctrl[4:0] == 5'h00) |=> com_oe == 4'h0 && seg_oe == 40'h0)
        else $error("commons driven with select zero");
    a_static_single: assert property (@(posedge mclk) disable iff (!resetn)
        (s_q.port_ctrl[7:5] == 3'h0 && s_q.port_ctrl[3:0] != 4'h0) |=> com_oe == 4'h1)
        else $error("static duty drives extra commons");
    a_quarter_all: assert property (@(posedge mclk) disable iff (!resetn)
        (s_q.port_ctrl[7:6] == 2'h3 && s_q.port_ctrl[3:0] != 4'h0) |=> com_oe == 4'hf)
        else $error("quarter duty missing commons");
    a_exp_pins: assert property (@(posedge mclk) disable iff (!resetn)
        (exp_active && s_q.disp_ctrl[5] && !s_q.stby_sync[1]) |=>
        segment_output[39] == $past(exp_latch_in))
        else $error("latch clock not on pin 40");
    a_standby_off: assert property (@(posedge mclk) disable iff (!resetn)
        s_q.stby_sync[1] |=> com_out == 4'h0 && segment_output == 40'h0)
        else $error("display driven in standby");
    a_exp_port: assert property (@(posedge mclk) disable iff (!resetn)
        (s_q.port_ctrl[4:0] == 5'h10) |=> seg_oe[39:36] == 4'h0)
        else $error("expansion pins driven with select zero");
    a_group_four: assert property (@(posedge mclk) disable iff (!resetn)
        seg_oe[0] |-> seg_oe[3:0] == 4'hf)
        else $error("segment group split");
    c_expansion: cover property (@(posedge mclk) exp_active);
    c_write: cover property (@(posedge mclk) s_axi_bvalid && s_axi_bready);
    c_read: cover property (@(posedge mclk) s_axi_rvalid && s_axi_rready);
endmodule

// ===== tb/lcdpds_panel_model.sv
`timescale 1ns/10ps

// ****************************************
// Panel wires with port logic on released pins
// ****************************************
module lcdpds_panel_model (
    // Clock
    input  wire logic        mclk,
    // Pins from the block
    input  wire logic [3:0]  com_out,
    input  wire logic [3:0]  com_oe,
    input  wire logic [39:0] segment_output,
    input  wire logic [39:0] seg_oe,
    // Levels on the wires
    output logic [3:0]       com_pin,
    output logic [39:0]      seg_pin
);
    logic port_q = 1'b0;

    // Port logic toggles so a stale driver level never passes
    always @(posedge mclk) begin
        port_q <= ~port_q;
    end

    always_comb begin
        com_pin = (com_out & com_oe) | ({4{port_q}} & ~com_oe);
        seg_pin = (segment_output & seg_oe) | ({40{port_q}} & ~seg_oe);
    end
endmodule

// ===== tb/testbench.sv
`timescale 1ns/10ps

module testbench;
    typedef struct {int k; logic [39:0] e; logic [39:0] m;} lcdpds_note_t;
    logic        mclk = 1'b0, resetn = 1'b0, snap = 1'b0, standby = 1'b0;
    logic [15:0] s_axi_awaddr = 16'h0, s_axi_araddr = 16'h0;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, lf = 32'h53;
    logic [3:0]  s_axi_wstrb = 4'h0, com_wave = 4'h0, com_out, com_oe, frame_select, com_pin;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, com_nonsel_wave = 1'b0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic        exp_latch_in = 1'b0, exp_shift_in = 1'b0, exp_data_in = 1'b0, exp_alt_in = 1'b0;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [39:0] seg_wave = 40'h0, segment_output, seg_oe, seg_pin;
    logic [7:0]  lcd_port_duty_control, cfg = 8'h0, disp = 8'h80;
    logic [31:0] d;
    int          n_errors = 0, n_compared = 0, cyc = 0;
    lcdpds_note_t q[$];
    string       nm[9] = '{"rdata", "rresp", "bresp", "com_out", "com_oe", "segment_output",
                           "seg_oe", "port_ctrl", "frame_select"};

    lcdpds_top i_dut (.mclk(mclk), .resetn(resetn), .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .standby(standby),
        .com_wave(com_wave), .com_nonsel_wave(com_nonsel_wave), .seg_wave(seg_wave),
        .exp_latch_in(exp_latch_in), .exp_shift_in(exp_shift_in), .exp_data_in(exp_data_in),
        .exp_alt_in(exp_alt_in), .com_out(com_out), .com_oe(com_oe),
        .segment_output(segment_output), .seg_oe(seg_oe),
        .lcd_port_duty_control(lcd_port_duty_control), .frame_select(frame_select));

    lcdpds_panel_model i_panel (.mclk(mclk), .com_out(com_out), .com_oe(com_oe),
        .segment_output(segment_output), .seg_oe(seg_oe), .com_pin(com_pin), .seg_pin(seg_pin));

    initial begin
        forever #4 mclk = ~mclk;
    end

    function automatic logic [31:0] rnd();
        repeat (32) lf = {lf[30:0], lf[31] ^ lf[21] ^ lf[1] ^ lf[0]};
        return lf;
    endfunction

    function automatic void put(input int k, input logic [39:0] e, input logic [39:0] m);
        q.push_back('{k, e, m});
    endfunction

    function automatic logic [39:0] seen(input int k);
        case (k)
            0: return {8'h0, s_axi_rdata};
            1: return {38'h0, s_axi_rresp};
            2: return {38'h0, s_axi_bresp};
            3: return {36'h0, com_out};
            4: return {36'h0, com_oe};
            5: return segment_output;
            6: return seg_oe;
            7: return {32'h0, lcd_port_duty_control};
            default: return {36'h0, frame_select};
        endcase
    endfunction

    task automatic cmp(input int k, input logic [39:0] s, input logic [39:0] e);
        n_compared++;
        if (s !== e) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", nm[k], e, s);
        end
    endtask

    task automatic take(input int k);
        lcdpds_note_t n;
        if (q.size() == 0 || q[0].k != k) begin
            cmp(k, seen(k), 40'hx);
        end else begin
            n = q.pop_front();
            cmp(k, seen(k) & n.m, n.e & n.m);
        end
    endtask

    // ****************************************
    // Result watcher
    // ****************************************
    always @(posedge mclk) begin
        if (s_axi_rvalid && s_axi_rready) begin
            take(0);
            take(1);
        end
        if (s_axi_bvalid && s_axi_bready) take(2);
        if (snap) for (int k = 3; k < 9; k++) take(k);
    end

    task automatic wr(input logic [15:0] a, input logic [31:0] v, input logic [3:0] s,
                      input logic [1:0] r);
        put(2, {38'h0, r}, 40'h3);
        @(posedge mclk);
        s_axi_awaddr  <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata   <= v;
        s_axi_wstrb   <= s;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        do begin
            @(posedge mclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
    endtask

    task automatic rd(input logic [15:0] a, input logic [31:0] e, input logic [31:0] m,
                      input logic [1:0] r);
        put(0, {8'h0, e}, {8'h0, m});
        put(1, {38'h0, r}, 40'h3);
        @(posedge mclk);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        do begin
            @(posedge mclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
    endtask

    task automatic stir();
        logic [31:0] u;
        u = rnd();
        seg_wave        <= {u[7:0], rnd()};
        com_wave        <= u[11:8];
        com_nonsel_wave <= u[12];
        exp_latch_in    <= u[13];
        exp_shift_in    <= u[14];
        exp_data_in     <= u[15];
        exp_alt_in      <= u[16];
    endtask

    task automatic pins(input logic sb);
        logic [3:0]  w, coe, cex;
        logic [39:0] soe, sex;
        int          n;
        w = com_wave;
        n = cfg[3] ? 9 + cfg[0] : (cfg[3:0] == 4'h0 ? 0 : cfg[3:0] + 1);
        soe = 40'h0;
        for (int g = 0; g < 10; g++) if (g >= 10 - n) soe[g*4 +: 4] = 4'hf;
        sex = seg_wave;
        if (cfg[4] && n > 0) sex[39:36] = {exp_latch_in, exp_shift_in, exp_data_in, exp_alt_in};
        case (cfg[7:6])
            2'h0: coe = 4'h1;
            2'h1: coe = 4'h3;
            2'h2: coe = 4'h7;
            default: coe = 4'hf;
        endcase
        if (cfg[5]) coe = 4'hf;
        if (!cfg[4] && cfg[3:0] == 4'h0) coe = 4'h0;
        case (cfg[7:6])
            2'h0: cex = {4{w[0]}};
            2'h1: cex = cfg[5] ? {w[1], w[1], w[0], w[0]} : w;
            2'h2: cex = {com_nonsel_wave, w[2:0]};
            default: cex = w;
        endcase
        if (sb) {cex, sex} = 44'h0;
        put(3, {36'h0, cex}, sb ? 40'hf : {36'h0, coe});
        put(4, {36'h0, coe}, {40{!sb}});
        put(5, sex, sb ? {40{1'b1}} : soe);
        put(6, soe, {40{!sb}});
        put(7, {32'h0, cfg}, 40'hff);
        put(8, {36'h0, disp[3:0]}, 40'hf);
        snap <= 1'b1;
        @(posedge mclk);
        snap <= 1'b0;
    endtask

    task automatic stop_test();
        if (n_errors == 0 && n_compared > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_errors++;
            stop_test();
        end
    end

    initial begin
        repeat (3) @(posedge mclk);
        resetn <= 1'b1;
        rd(16'hffc0, 32'h8000, 32'hffff, 2'h0);
        pins(1'b0);
        disp = 8'ha0;
        wr(16'hffc0, 32'h2000, 4'h2, 2'h0);
        for (int c = 0; c < 256; c++) begin
            cfg = c[7:0];
            wr(16'hffc0, {24'h0, cfg}, 4'h1, 2'h0);
            stir();
            repeat (4) @(posedge mclk);
            pins(1'b0);
        end
        rd(16'hffc4, 32'h2f0, 32'hffffffff, 2'h0);
        disp = 8'had;
        wr(16'hffc0, 32'h2d00, 4'h2, 2'h0);
        rd(16'hffc0, {16'h0, disp, cfg}, 32'hffff, 2'h0);
        standby <= 1'b1;
        repeat (6) @(posedge mclk);
        pins(1'b1);
        standby <= 1'b0;
        d = rnd();
        wr(16'hf740, d, 4'hf, 2'h0);
        wr(16'hf77c, ~d, 4'hf, 2'h0);
        wr(16'hf740, 32'ha500, 4'h2, 2'h0);
        rd(16'hf740, {d[31:16], 8'ha5, d[7:0]}, 32'hffffffff, 2'h0);
        rd(16'hf77c, ~d, 32'hffffffff, 2'h0);
        rd(16'hf780, 32'h0, 32'hffffffff, 2'h2);
        wr(16'hfff0, 32'h1, 4'hf, 2'h2);
        repeat (4) @(posedge mclk);
        stop_test();
    end
endmodule
